/* File: shared/pkt_fmt_params.svh */
// Register offsets, field positions, reset values and limits of the channel packet formatter
`ifndef PKT_FMT_PARAMS_SVH
`define PKT_FMT_PARAMS_SVH

`define REG_CTRL        8'h00
`define REG_RATE        8'h04
`define REG_TIMING      8'h08
`define REG_CARD        8'h0C
`define REG_WORDS       8'h10
`define REG_BLOCK_LEN   8'h14
`define REG_STATUS      8'h18

`define CTRL_INT_CLK    0
`define CTRL_DIGITAL    1
`define CTRL_DC_COUPLE  2
`define CTRL_FILL_EN    3

`define HW_INT_CLK      23
`define HW_DIGITAL      22
`define HW_OVERRUN      21
`define HW_OVERRANGE    20
`define HW_EMPTY        19
`define HW_COUPLING     16

`define KIND_MUX        6'h03
`define KIND_STEREO     6'h04
`define FILL_WORD       24'hFFFFFF
`define WORD_BITS       24
`define MAX_BLOCK_WORDS 12'h800
`define BLOCK_LEN_RST   12'h800
`define HDR_LAST_IDX    2'h3
`endif

/* File: shared/pkt_fmt_pkg.sv */
// Types shared by the channel packet formatter and its bench
package pkt_fmt_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_DATA, ST_FILL} fmt_state_t;

    // One word entering from the acquisition side; last marks the trailing partial word
    typedef struct packed {
        logic        last;
        logic [23:0] word;
    } in_beat_t;

    typedef enum logic [1:0] {W_HEADER, W_DATA, W_PARTIAL, W_FILL} word_kind_t;

    typedef struct packed {
        word_kind_t  kind;
        logic [23:0] word;
    } out_beat_t;
endpackage

/* File: verilog/channel_packet_header_formatter.sv */
// Channel packet formatter: header words, data, trailing partial word and fill, with APB setup
`include "pkt_fmt_params.svh"

// Behaviour
// - Header bit 23 marks internal channel clock
// - Header bit 22 marks digital channel
// - Bit 21 reports overrun in previous block
// - Bit 20 reports overrange in current block; code reports events seen up to this block's marker
// - Bit 19 marks block without samples
// - Internal clock: divisor in low sixteen bits
// - External clock: full rate field, 250 Hz
// - Delay field is clock periods minus one
// - Coupling bit one for dc coupling
// - Card parameter zero for kinds 0-2
// - Mux kind: subchannel count, first subchannel
// - Two spare bits above kind always zero
// - Six-bit card kind code
// - Stereo: left upper byte, right lower
// - Partial word, first sample in MSBs
// - Fixed rate pads with all-ones fill
// - Variable blocks never exceed 2048 words
// - Four header words per active channel
// - Partial status zero or rounded-up unused/size
module channel_packet_header_formatter (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  block_marker,
    input  wire logic                  overrange_event,
    input  wire logic                  in_valid,
    input  wire pkt_fmt_pkg::in_beat_t in_beat,
    output logic                       in_ready,
    output logic                       out_valid,
    output pkt_fmt_pkg::out_beat_t     out_beat,
    input  wire logic                  out_ready
);
    import pkt_fmt_pkg::*;

    logic [3:0]  ctrl;
    logic [18:0] rate;
    logic [23:0] timing;
    logic [23:0] card;
    logic [28:0] words_cfg;
    logic [11:0] block_len;
    fmt_state_t  state;
    logic [1:0]  hdr_idx;
    logic [11:0] total;
    logic [10:0] data_cnt;
    logic        run_overrun;
    logic        prior_overrun;
    logic        run_overrange;
    logic        blk_overrange;
    logic        adv;
    logic        wr_en;
    logic        rd_hit;
    logic [23:0] hdr_word;
    logic [23:0] data_word;
    logic [7:0]  card_param;
    logic [11:0] len_cap;
    logic        drop_word;

    // Sample size in bits from the four-bit format code
    function automatic logic [4:0] sample_bits(input logic [3:0] fmt);
        if (fmt >= 4'h8) begin
            sample_bits = 5'({fmt, 1'b0} - 5'd6);
        end else begin
            sample_bits = 5'(fmt) + 5'd1;
        end
    endfunction

    function automatic logic [4:0] partial_status(input logic [4:0] cnt, input logic [3:0] fmt);
        logic [9:0] used;
        logic [4:0] sz;
        logic [4:0] unused;
        sz     = sample_bits(fmt);
        used   = 10'(cnt) * 10'(sz);
        unused = (used >= 10'd24) ? 5'd0 : 5'(10'd24 - used);
        if (cnt == 5'd0) begin
            partial_status = 5'd0;
        end else begin
            partial_status = 5'((unused + sz - 5'd1) / sz);
        end
    endfunction

    // Register bus: zero-wait slave, unmapped addresses answer with an error
    assign pready = 1'b1;
    assign wr_en  = psel && penable && pwrite;
    assign rd_hit = (paddr <= `REG_STATUS) && (paddr[1:0] == 2'b00);

    always_comb begin
        pslverr = psel && penable && !rd_hit;
        case (paddr)
            `REG_CTRL:      prdata = {28'h0000000, ctrl};
            `REG_RATE:      prdata = {13'h0000, rate};
            `REG_TIMING:    prdata = {8'h00, timing};
            `REG_CARD:      prdata = {8'h00, card};
            `REG_WORDS:     prdata = {3'h0, words_cfg};
            `REG_BLOCK_LEN: prdata = {20'h00000, block_len};
            `REG_STATUS:    prdata = {16'h0000, prior_overrun, run_overrange, run_overrun,
                                      (state != ST_IDLE), total};
            default:        prdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl      <= 4'h0;
            rate      <= 19'h00000;
            timing    <= 24'h000000;
            card      <= 24'h000000;
            words_cfg <= 29'h00000000;
            block_len <= `BLOCK_LEN_RST;
        end else if (wr_en) begin
            case (paddr)
                `REG_CTRL:      ctrl      <= pwdata[3:0];
                `REG_RATE:      rate      <= pwdata[18:0];
                `REG_TIMING:    timing    <= pwdata[23:0];
                `REG_CARD:      card      <= pwdata[23:0];
                `REG_WORDS:     words_cfg <= pwdata[28:0];
                `REG_BLOCK_LEN: block_len <= pwdata[11:0];
                default:        ;
            endcase
        end
    end

    // Lengths above the format limit are clamped so a block can never grow past it
    assign len_cap = (block_len > `MAX_BLOCK_WORDS || block_len == 12'h000)
                     ? `MAX_BLOCK_WORDS : block_len;

    always_comb begin
        if (card[5:0] == `KIND_MUX) begin
            card_param = {card[19:16], card[23:20]};
        end else begin
            card_param = 8'h00;
        end
    end

    // card: [5:0] kind, [9:8] decade, [14:10] gain, [19:16] subchannels, [23:20] first sub
    // words_cfg: [10:0] count, [14:11] format, [18:15] channel, [23:19] partial samples
    always_comb begin
        case (hdr_idx)
            2'h0: hdr_word = {words_cfg[18:15], words_cfg[14:11], words_cfg[10:0],
                              partial_status(words_cfg[23:19], words_cfg[14:11])};
            2'h1: begin
                hdr_word = 24'h000000;
                hdr_word[`HW_INT_CLK]   = ctrl[`CTRL_INT_CLK];
                hdr_word[`HW_DIGITAL]   = ctrl[`CTRL_DIGITAL];
                hdr_word[`HW_OVERRUN]   = prior_overrun;
                hdr_word[`HW_OVERRANGE] = blk_overrange;
                hdr_word[`HW_EMPTY]     = (words_cfg[10:0] == 11'h000)
                                          && (words_cfg[23:19] == 5'h00);
                if (ctrl[`CTRL_INT_CLK]) begin
                    hdr_word[15:0] = rate[15:0];
                end else begin
                    hdr_word[18:0] = rate;
                end
            end
            2'h2: hdr_word = {timing[23:16],
                              (timing[15:0] == 16'h0000) ? 16'h0000
                                                        : timing[15:0] - 16'h0001};
            default: begin
                hdr_word = {card[9:8], card[14:10], 1'b0, card_param, 2'b00, card[5:0]};
                hdr_word[`HW_COUPLING] = ctrl[`CTRL_DC_COUPLE];
                // Spare pair stays zero from the concatenation above
            end
        endcase
    end

    // Stereo sources present the left sample low and the right sample above it
    always_comb begin
        if (card[5:0] == `KIND_STEREO) begin
            data_word = {8'h00, in_beat.word[7:0], in_beat.word[15:8]};
        end else begin
            data_word = in_beat.word;
        end
    end

    assign adv       = !out_valid || out_ready;
    assign in_ready  = (state == ST_DATA) && adv;
    // One slot is held back for the partial word; words past the count or the length are lost
    assign drop_word = (data_cnt >= words_cfg[10:0]) || (total >= len_cap - 12'h001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= ST_IDLE;
            hdr_idx <= 2'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (block_marker) begin
                        state   <= ST_HDR;
                        hdr_idx <= 2'h0;
                    end
                end
                ST_HDR: begin
                    if (adv) begin
                        hdr_idx <= hdr_idx + 2'h1;
                        if (hdr_idx == `HDR_LAST_IDX) begin
                            state <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (in_valid && in_ready && in_beat.last) begin
                        if (ctrl[`CTRL_FILL_EN] && (total + 12'h001 < len_cap)) begin
                            state <= ST_FILL;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_FILL: begin
                    if (adv && (total + 12'h001 >= len_cap)) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_beat  <= '0;
        end else if (adv) begin
            out_valid <= 1'b0;
            case (state)
                ST_HDR: begin
                    out_valid <= 1'b1;
                    out_beat  <= '{kind: W_HEADER, word: hdr_word};
                end
                ST_DATA: begin
                    if (in_valid && in_beat.last) begin
                        out_valid <= 1'b1;
                        out_beat  <= '{kind: W_PARTIAL, word: in_beat.word};
                    end else if (in_valid && !drop_word) begin
                        out_valid <= 1'b1;
                        out_beat  <= '{kind: W_DATA, word: data_word};
                    end
                end
                ST_FILL: begin
                    out_valid <= 1'b1;
                    out_beat  <= '{kind: W_FILL, word: `FILL_WORD};
                end
                default: ;
            endcase
        end
    end

    // Word accounting for the block being formatted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            total    <= 12'h000;
            data_cnt <= 11'h000;
        end else if (state == ST_IDLE && block_marker) begin
            total    <= 12'h000;
            data_cnt <= 11'h000;
        end else if (adv && (state == ST_HDR || state == ST_FILL
                             || (state == ST_DATA && in_valid && (in_beat.last || !drop_word)))) begin
            total <= total + 12'h001;
            if (state == ST_DATA && !in_beat.last) begin
                data_cnt <= data_cnt + 11'h001;
            end
        end
    end

    // Overrun of this block is reported in the next header; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_overrun   <= 1'b0;
            prior_overrun <= 1'b0;
        end else begin
            if (block_marker && state == ST_IDLE) begin
                prior_overrun <= run_overrun;
                run_overrun   <= 1'b0;
            end
            if ((state == ST_DATA && in_valid && in_ready && !in_beat.last && drop_word)
                || (block_marker && state != ST_IDLE)) begin
                run_overrun <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_overrange <= 1'b0;
            blk_overrange <= 1'b0;
        end else begin
            if (block_marker && state == ST_IDLE) begin
                blk_overrange <= run_overrange || overrange_event;
                run_overrange <= 1'b0;
            end else if (overrange_event) begin
                run_overrange <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    fill_all_ones_a: assert property (state == ST_FILL && adv |=> out_valid
        && out_beat.kind == W_FILL && out_beat.word == 24'hFFFFFF) else $error("fill word wrong");
    block_len_cap_a: assert property (total <= 12'h800)
        else $error("block longer than 2048 words");
    header_count_a: assert property ($rose(state == ST_DATA)
        |-> $past(state) == ST_HDR && $past(hdr_idx) == 2'h3 && hdr_idx == 2'h0)
        else $error("header run not four words");
    int_clock_bit_a: assert property (out_valid
        && out_beat.kind == W_HEADER && $past(hdr_idx) == 2'h1 && $past(adv)
        |-> out_beat.word[23] == ctrl[0] && (!ctrl[0] || out_beat.word[18:16] == 3'h0))
        else $error("clock source or rate field wrong");
    spare_zero_a: assert property (out_valid && out_beat.kind == W_HEADER
        && $past(hdr_idx) == 2'h3 && $past(adv) |-> out_beat.word[7:6] == 2'b00)
        else $error("spare bits not zero");
    param_zero_a: assert property (out_valid && $past(hdr_idx) == 2'h3
        && $past(adv) && out_beat.kind == W_HEADER && out_beat.word[5:0] < 6'h03
        |-> out_beat.word[15:8] == 8'h00) else $error("card parameter not zero");
    partial_last_a: assert property (out_valid && out_beat.kind == W_PARTIAL
        |=> state == ST_FILL || state == ST_IDLE) else $error("partial word not last");
    data_after_hdr_a: assert property (state == ST_HDR && hdr_idx == 2'h3 && adv
        |=> state == ST_DATA && out_beat.kind == W_HEADER)
        else $error("data began before headers");
    overrun_carry_a: assert property (block_marker && run_overrun
        && state == ST_IDLE |=> prior_overrun && !run_overrun) else $error("overrun not carried");

    full_block_c:   cover property (state == ST_FILL ##1 state == ST_IDLE);
    variable_blk_c: cover property (out_valid && out_beat.kind == W_PARTIAL && !ctrl[3]);
    overrun_c:      cover property (prior_overrun && state == ST_HDR);
endmodule // channel_packet_header_formatter

/* File: dv/recorder_model.sv */
// Behavioural recorder that accepts the formatter's output stream, promptly or with stalls
module recorder_model (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   slow,
    input  wire logic                   out_valid,
    input  wire pkt_fmt_pkg::out_beat_t out_beat,
    output logic                        out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    import pkt_fmt_pkg::*;

    out_beat_t got[$];
    logic      phase;

    // Stalling every other cycle makes the formatter hold each beat across a refused edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ready <= 1'b0;
            phase     <= 1'b0;
            got.delete();
        end else begin
            phase     <= ~phase;
            out_ready <= slow ? phase : 1'b1;
            if (out_valid && out_ready) begin
                got.push_back(out_beat);
            end
        end
    end
endmodule // recorder_model

/* File: dv/channel_packet_header_formatter_tb.sv */
// Self-checking bench of the channel packet formatter
`include "pkt_fmt_params.svh"
module channel_packet_header_formatter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pkt_fmt_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        block_marker, overrange_event, in_valid, in_ready, out_valid, out_ready, slow;
    in_beat_t    in_beat;
    out_beat_t   out_beat;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    channel_packet_header_formatter i_channel_packet_header_formatter (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .block_marker(block_marker), .overrange_event(overrange_event), .in_valid(in_valid),
        .in_beat(in_beat), .in_ready(in_ready), .out_valid(out_valid), .out_beat(out_beat),
        .out_ready(out_ready));
    recorder_model i_recorder_model (.pclk(pclk), .presetn(presetn), .slow(slow),
        .out_valid(out_valid), .out_beat(out_beat), .out_ready(out_ready));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // A hung handshake would otherwise stall the run forever
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            tally_and_finish;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // The wait for pready ends on the first edge that sees it high, else at the bench timeout
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, a, 32'h0, rd, e);
        chk(rd, exp);
        chk({31'h0, e}, {31'h0, experr});
    endtask

    // Data beats are held until taken; the caller lowers in_valid after the last one
    task automatic send_beat(input logic last, input logic [23:0] w);
        in_valid <= 1'b1;
        in_beat <= {last, w};
        do begin
            @(posedge pclk);
        end while (!(in_valid === 1'b1 && in_ready === 1'b1));
    endtask

    task automatic block(input int nd, input logic [23:0] d0, input logic [23:0] pw);
        @(posedge pclk) block_marker <= 1'b1;
        @(posedge pclk) block_marker <= 1'b0;
        for (int i = 0; i < nd; i++) send_beat(1'b0, d0 + 24'(i));
        send_beat(1'b1, pw);
        in_valid <= 1'b0;
    endtask

    task automatic expb(input word_kind_t k, input logic [23:0] w, input logic [23:0] m);
        out_beat_t b;
        int        n;
        n = 0;
        while (i_recorder_model.got.size() == 0 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        b = 'x;
        if (i_recorder_model.got.size() != 0) b = i_recorder_model.got.pop_front();
        chk(32'(b) & {8'h03, m}, 32'({k, w}) & {8'h03, m});
    endtask

    task automatic hdr(input logic [23:0] e0, e1, e2, e3, m3);
        expb(W_HEADER, e0, 24'hFFFFFF);
        expb(W_HEADER, e1, 24'hFFFFFF);
        expb(W_HEADER, e2, 24'hFFFFFF);
        expb(W_HEADER, e3, m3);
    endtask

    task automatic t_regs;
        rdchk(`REG_BLOCK_LEN, 32'h800, 1'b0);
        rdchk(`REG_STATUS, 32'h0, 1'b0);
        wr(`REG_CTRL, 32'h7);
        rdchk(`REG_CTRL, 32'h7, 1'b0);
        rdchk(8'h1C, 32'h0, 1'b1);
        $display("test registers done");
    endtask

    // One word past the count forces an overrun that the next block must report
    task automatic t_internal;
        wr(`REG_RATE, 32'h0007ABCD);
        wr(`REG_TIMING, {8'h0, 8'h5A, 16'h0010});
        wr(`REG_CARD, {8'h0, 4'd4, 4'd9, 1'b0, 5'd31, 2'd2, 2'b0, 6'd3});
        wr(`REG_WORDS, {8'h0, 5'd2, 4'd5, 4'd7, 11'd2});
        @(posedge pclk) overrange_event <= 1'b1;
        @(posedge pclk) overrange_event <= 1'b0;
        block(3, 24'h111111, 24'hA5B6C7);
        hdr({4'd5, 4'd7, 11'd2, 5'd1}, {5'b11010, 3'b0, 16'hABCD}, {8'h5A, 16'h000F},
            {2'd2, 5'd31, 1'b1, 8'h94, 2'b0, 6'd3}, 24'hFFFFFF);
        expb(W_DATA, 24'h111111, 24'hFFFFFF);
        expb(W_DATA, 24'h111112, 24'hFFFFFF);
        expb(W_PARTIAL, 24'hA5B6C7, 24'hFFFFFF);
        // Seven words out, third data word dropped: overrun of this block pending
        rdchk(`REG_STATUS, 32'h2007, 1'b0);
        $display("test internal clock done");
    endtask

    task automatic t_external;
        wr(`REG_CTRL, 32'h0);
        wr(`REG_TIMING, 32'h0);
        wr(`REG_CARD, {8'h0, 4'd4, 4'd9, 1'b0, 5'd0, 2'd1, 2'b0, 6'd0});
        wr(`REG_WORDS, 32'h0);
        block(0, 24'h0, 24'h0);
        hdr(24'h0, {5'b00101, 19'h7ABCD}, 24'h0, {2'd1, 5'd0, 1'b0, 8'h00, 2'b0, 6'd0},
            24'hFFFFFF);
        expb(W_PARTIAL, 24'h0, 24'hFFFFFF);
        $display("test external clock done");
    endtask

    // A marker arriving while fill is still pending must flag the following block
    task automatic t_fill;
        wr(`REG_BLOCK_LEN, 32'd12);
        wr(`REG_CTRL, 32'h9);
        wr(`REG_WORDS, {8'h0, 5'd0, 4'd0, 4'd15, 11'd1});
        slow <= 1'b1;
        block(1, 24'h222222, 24'h333333);
        @(posedge pclk) block_marker <= 1'b1;
        @(posedge pclk) block_marker <= 1'b0;
        hdr({4'd0, 4'd15, 11'd1, 5'd0}, {5'b10000, 3'b0, 16'hABCD}, 24'h0,
            {2'd1, 5'd0, 1'b0, 8'h00, 2'b0, 6'd0}, 24'hFFFFFF);
        expb(W_DATA, 24'h222222, 24'hFFFFFF);
        expb(W_PARTIAL, 24'h333333, 24'hFFFFFF);
        for (int i = 0; i < 6; i++) expb(W_FILL, `FILL_WORD, 24'hFFFFFF);
        slow <= 1'b0;
        $display("test fill done");
    endtask

    task automatic t_kinds;
        logic [5:0]  kk;
        logic [23:0] dexp;
        wr(`REG_CTRL, 32'h2);
        for (int k = 0; k < 6; k++) begin
            kk = k[5:0];
            dexp = (k == 4) ? 24'h00A53C : 24'h003CA5;
            wr(`REG_CARD, {8'h0, 4'd4, 4'd9, 1'b0, 5'd0, 2'd0, 2'b0, kk});
            block(1, 24'h003CA5, 24'h0);
            hdr({4'd0, 4'd15, 11'd1, 5'd0}, {2'b01, k == 0, 2'b00, 19'h7ABCD}, 24'h0,
                {8'h0, (k == 3) ? 8'h94 : 8'h00, 2'b0, kk}, (k > 3) ? 24'hFF00FF : 24'hFFFFFF);
            expb(W_DATA, dexp, 24'hFFFFFF);
            expb(W_PARTIAL, 24'h0, 24'hFFFFFF);
        end
        $display("test card kinds done");
    endtask

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
        pwdata = 32'h0; block_marker = 1'b0; overrange_event = 1'b0; in_valid = 1'b0;
        in_beat = '0;
        slow = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_internal;
        t_external;
        t_fill;
        t_kinds;
        tally_and_finish;
    end
endmodule // channel_packet_header_formatter_tb
